// File: hw/mpss_defines.svh
// Timing counts and constants for the mote power-state sequencer
//-----------------------------------------------------------------------------
// Operation
//-----------------------------------------------------------------------------
// Operation
// - Start on power-on reset or reset pin
// - Synchronise reset pin, then load fuse table
// - Sample both pins; emulation only if both
// - Emulation suspends normal operation, acts as flash
// - Reset alone: minimum energy until released
// - Reset released: boot, then active state
// - Pick lowest power operational state automatically
// - Active keeps relaxation oscillator, CPU runs/sleeps
// - DMA and peripherals switch active/doze alone
// - Doze only when all peripherals, CPU idle
// - Doze keeps state, low-frequency oscillator, timers
// - Doze wakes quickly on I/O activity unless both pins toggle in one cycle
`ifndef MPSS_DEFINES_SVH
`define MPSS_DEFINES_SVH
// Fuse table load time in ns and derived cycles
`define MPSS_CLK_PERIOD_NS 10
`define MPSS_FUSE_LOAD_NS 640
`define MPSS_FUSE_LOAD_CYC (`MPSS_FUSE_LOAD_NS / `MPSS_CLK_PERIOD_NS)
// Boot sequence time in ns and derived cycles
`define MPSS_BOOT_NS 2560
`define MPSS_BOOT_CYC (`MPSS_BOOT_NS / `MPSS_CLK_PERIOD_NS)
// Low-frequency oscillator rate in Hz, and clock rate
`define MPSS_LFO_HZ 32768
`define MPSS_CLK_HZ 100000000
// Fuse word reset value
`define MPSS_FUSE_RESET 16'h0000
// Register reset values; pin stages start at the idle level of their pins
`define MPSS_RST_SYNC_RESET 2'h3
`define MPSS_RST_PREV_RESET 1'h1
`define MPSS_IO_SYNC_RESET 2'h0
`define MPSS_IO_PREV_RESET 1'h0
`define MPSS_CNT_RESET 16'h0000
`define MPSS_LF_RESET 32'h00000000
`endif

// File: hw/mpss_pkg.sv
// Types for the mote power-state sequencer
package mpss_pkg;
	typedef enum logic [3:0] {
		MPSS_POR,
		MPSS_FUSE_LOAD,
		MPSS_SAMPLE,
		MPSS_FLASH_EMU,
		MPSS_MIN_ENERGY,
		MPSS_BOOT,
		MPSS_ACT_RUN,
		MPSS_ACT_IDLE,
		MPSS_DOZE
	} mpss_state_t;

	// Activity requests from the rest of the chip
	typedef struct packed {
		logic cpu_busy;
		logic cpu_sleep_now;
		logic periph_busy;
		logic dma_busy;
		logic io_wake;
	} mpss_activity_t;

	// Power controls to the rest of the chip
	typedef struct packed {
		logic relax_osc_en;
		logic lf_osc_en;
		logic cpu_clk_en;
		logic periph_en;
		logic retain;
		logic flash_emu;
		logic min_energy;
		logic fuse_load;
		logic boot;
	} mpss_power_t;

	// Whole module state
	typedef struct packed {
		mpss_state_t state;
		logic [1:0] rst_sync;
		logic rst_prev;
		logic [15:0] cnt;
		logic [15:0] fuse_dir;
		logic [1:0] io_sync;
		logic io_prev;
		logic [31:0] lf_acc;
		logic [31:0] lf_time;
		mpss_power_t pwr;
	} mpss_regs_t;
endpackage

// File: hw/mpss_sequencer.sv
// Mote power-state sequencer: start-up, flash emulation and operational states
`timescale 1ns/1ns
`include "mpss_defines.svh"
module mpss_sequencer import mpss_pkg::*; #(
	parameter int FUSE_CYC = `MPSS_FUSE_LOAD_CYC,
	parameter int BOOT_CYC = `MPSS_BOOT_CYC
) (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// External pins
	input wire logic ext_reset_low_i,
	input wire logic flash_program_enable_low_i,
	input wire logic time_strobe_low_i,
	input wire logic uart_rx_i,
	// Fuse table contents
	input wire logic [15:0] fuse_dir_i,
	// Activity from CPU, DMA and peripherals
	input wire mpss_activity_t act_i,
	// Power controls and status
	output mpss_power_t pwr_o,
	output logic [15:0] io_dir_o,
	output mpss_state_t state_o,
	output logic [31:0] lf_time_o,
	output logic lf_tick_o
);

	mpss_regs_t r;
	mpss_regs_t next_r;
	logic rst_asserted;
	logic rst_fall;
	logic io_edge;
	logic busy;
	logic [32:0] lf_sum;

	// Reset record; pin stages start at their idle levels so no false edge follows reset
	localparam mpss_regs_t REGS_RESET = '{
		state: MPSS_POR,
		rst_sync: `MPSS_RST_SYNC_RESET,
		rst_prev: `MPSS_RST_PREV_RESET,
		cnt: `MPSS_CNT_RESET,
		fuse_dir: `MPSS_FUSE_RESET,
		io_sync: `MPSS_IO_SYNC_RESET,
		io_prev: `MPSS_IO_PREV_RESET,
		lf_acc: `MPSS_LF_RESET,
		lf_time: `MPSS_LF_RESET,
		pwr: '0
	};

	//-------------------------------------------------------------------------
	// Derived conditions
	//-------------------------------------------------------------------------
	// Synchronised reset pin; only the second stage is looked at
	assign rst_asserted = ~r.rst_sync[1];
	// Falling edge of the synchronised pin starts a new sequence
	assign rst_fall = r.rst_prev & ~r.rst_sync[1];
	// A change of the combined pin level is activity; edges on both pins in one cycle cancel
	assign io_edge = r.io_sync[1] ^ r.io_prev;
	// Anything keeping the chip awake
	assign busy = act_i.cpu_busy | act_i.periph_busy | act_i.dma_busy | act_i.io_wake;
	// Fractional accumulator gives a low-frequency tick from the fast clock
	assign lf_sum = {1'b0, r.lf_acc} + 33'(`MPSS_LFO_HZ);

	//-------------------------------------------------------------------------
	// Power decode
	//-------------------------------------------------------------------------
	// Every control is spelled out per state so none is left on by accident
	function automatic mpss_power_t power_for(mpss_state_t s, mpss_activity_t a);
		mpss_power_t p;
		// The clear only guards states added later; each branch lists all nine
		p = '0;
		case (s)
			MPSS_POR: begin
				// Nothing runs until the first edge after power-on reset
				p.relax_osc_en = 1'b0;
				p.lf_osc_en = 1'b0;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_FUSE_LOAD: begin
				// Only the fuse reader runs while pin directions settle
				p.relax_osc_en = 1'b0;
				p.lf_osc_en = 1'b0;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b1;
				p.boot = 1'b0;
			end
			MPSS_SAMPLE: begin
				// One quiet cycle while both pins are sampled
				p.relax_osc_en = 1'b0;
				p.lf_osc_en = 1'b0;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_FLASH_EMU: begin
				// Normal operation stops; the oscillator serves the flash emulation
				p.relax_osc_en = 1'b1;
				p.lf_osc_en = 1'b0;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b1;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_MIN_ENERGY: begin
				// Everything off but the minimum-energy hold
				p.relax_osc_en = 1'b0;
				p.lf_osc_en = 1'b0;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b1;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_BOOT: begin
				// Boot needs the fast clocks; the low-frequency oscillator is enabled from here
				p.relax_osc_en = 1'b1;
				p.lf_osc_en = 1'b1;
				p.cpu_clk_en = 1'b1;
				p.periph_en = 1'b0;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b1;
			end
			MPSS_ACT_RUN: begin
				// Fast oscillator and CPU clock; peripherals only when asked
				p.relax_osc_en = 1'b1;
				p.lf_osc_en = 1'b1;
				p.cpu_clk_en = 1'b1;
				p.periph_en = a.periph_busy | a.dma_busy;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_ACT_IDLE: begin
				// CPU clock stops while DMA and peripherals carry on
				p.relax_osc_en = 1'b1;
				p.lf_osc_en = 1'b1;
				p.cpu_clk_en = 1'b0;
				p.periph_en = a.periph_busy | a.dma_busy;
				p.retain = 1'b0;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			MPSS_DOZE: begin
				// Only the slow oscillator and state retention stay up
				p.relax_osc_en = 1'b0;
				p.lf_osc_en = 1'b1;
				p.cpu_clk_en = 1'b0;
				p.periph_en = 1'b0;
				p.retain = 1'b1;
				p.flash_emu = 1'b0;
				p.min_energy = 1'b0;
				p.fuse_load = 1'b0;
				p.boot = 1'b0;
			end
			default: p = '0;
		endcase
		return p;
	endfunction

	//-------------------------------------------------------------------------
	// Next-state logic
	//-------------------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.rst_sync = {r.rst_sync[0], ext_reset_low_i};
		next_r.rst_prev = r.rst_sync[1];
		next_r.io_sync = {r.io_sync[0], time_strobe_low_i ^ uart_rx_i};
		next_r.io_prev = r.io_sync[1];
		next_r.cnt = (r.cnt == 16'h0000) ? 16'h0000 : r.cnt - 16'h0001;
		// Timekeeping runs in every operational state, doze included
		if (lf_sum >= 33'(`MPSS_CLK_HZ)) begin
			next_r.lf_acc = 32'(lf_sum - 33'(`MPSS_CLK_HZ));
			next_r.lf_time = r.lf_time + 32'h00000001;
		end else begin
			next_r.lf_acc = lf_sum[31:0];
		end
		case (r.state)
			MPSS_POR: begin
				// Power-on reset just completed
				next_r.state = MPSS_FUSE_LOAD;
				next_r.cnt = 16'(FUSE_CYC);
			end
			MPSS_FUSE_LOAD: begin
				// Fuse table sets pin directions
				next_r.fuse_dir = fuse_dir_i;
				if (r.cnt <= 16'h0001) begin
					next_r.state = MPSS_SAMPLE;
				end
			end
			MPSS_SAMPLE: begin
				// Both pins low selects programming; reset alone parks the chip
				if (rst_asserted && !flash_program_enable_low_i) begin
					next_r.state = MPSS_FLASH_EMU;
				end else if (rst_asserted) begin
					next_r.state = MPSS_MIN_ENERGY;
				end else begin
					next_r.state = MPSS_BOOT;
					next_r.cnt = 16'(BOOT_CYC);
				end
			end
			MPSS_FLASH_EMU: begin
				// Left when reset is released, going straight to boot without a sequence restart
				if (!rst_asserted) begin
					next_r.state = MPSS_BOOT;
					next_r.cnt = 16'(BOOT_CYC);
				end
			end
			MPSS_MIN_ENERGY: begin
				// Parked at minimum energy until the pin is released
				if (!rst_asserted) begin
					next_r.state = MPSS_BOOT;
					next_r.cnt = 16'(BOOT_CYC);
				end
			end
			MPSS_BOOT: begin
				// Boot runs its full count before the CPU is handed over
				if (r.cnt <= 16'h0001) begin
					next_r.state = MPSS_ACT_RUN;
				end
			end
			MPSS_ACT_RUN: begin
				// Drop to the cheapest state that still serves demand
				if (!busy) begin
					next_r.state = MPSS_DOZE;
				end else if (act_i.cpu_sleep_now && !act_i.cpu_busy) begin
					next_r.state = MPSS_ACT_IDLE;
				end
			end
			MPSS_ACT_IDLE: begin
				// DMA and peripherals keep working with the CPU asleep
				if (act_i.cpu_busy) begin
					next_r.state = MPSS_ACT_RUN;
				end else if (!busy) begin
					next_r.state = MPSS_DOZE;
				end
			end
			MPSS_DOZE: begin
				// Peripherals wake without the CPU; CPU request goes straight to run
				if (act_i.cpu_busy || io_edge) begin
					next_r.state = MPSS_ACT_RUN;
				end else if (busy) begin
					next_r.state = MPSS_ACT_IDLE;
				end
			end
			default: begin
				// An unused code restarts the whole sequence
				next_r.state = MPSS_POR;
			end
		endcase
		// Reset pin edge restarts from fuse load, overriding everything
		if (rst_fall) begin
			next_r.state = MPSS_FUSE_LOAD;
			next_r.cnt = 16'(FUSE_CYC);
		end
		// Power controls follow the next state so they change with it
		next_r.pwr = power_for(next_r.state, act_i);
	end

	//-------------------------------------------------------------------------
	// State register
	//-------------------------------------------------------------------------
	// Pin synchroniser resets to the released level so no false edge appears
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= REGS_RESET;
		end else begin
			r <= next_r;
		end
	end

	//-------------------------------------------------------------------------
	// Outputs
	//-------------------------------------------------------------------------
	assign pwr_o = r.pwr;
	assign io_dir_o = r.fuse_dir;
	assign state_o = r.state;
	assign lf_time_o = r.lf_time;
	// One-cycle tick each low-frequency period; limited by accumulator rounding
	assign lf_tick_o = (lf_sum >= 33'(`MPSS_CLK_HZ));

endmodule // mpss_sequencer

// File: test/mpss_asserts.sv
// Port checks for the power-state sequencer
`timescale 1ns/1ns
module mpss_asserts import mpss_pkg::*; #(
	parameter int FUSE_CYC = 4,
	parameter int BOOT_CYC = 4
) (
	// Clock, reset and activity
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire mpss_activity_t act_i,
	// Watched outputs
	input wire mpss_power_t pwr_o,
	input wire mpss_state_t state_o,
	input wire logic [31:0] lf_time_o,
	input wire logic lf_tick_o
);
	mpss_state_t prev;
	logic [15:0] run;
	logic busy;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// The CPU sleep hint alone does not count as busy
	assign busy = act_i.cpu_busy | act_i.periph_busy | act_i.dma_busy | act_i.io_wake;
	// Cycles in the current state; a repetition could not hold these counts
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prev <= MPSS_POR;
			run <= 16'h0000;
		end else begin
			prev <= state_o;
			run <= (state_o != prev) ? 16'h0001 : run + 16'h0001;
		end
	end
	por_start_a: assert property (state_o == MPSS_POR |=> state_o == MPSS_FUSE_LOAD)
		else $error("no fuse load after reset");
	fuse_len_a: assert property (prev == MPSS_FUSE_LOAD && state_o != MPSS_FUSE_LOAD
		|-> state_o == MPSS_SAMPLE && run == FUSE_CYC) else $error("fuse load length");
	boot_len_a: assert property (prev == MPSS_BOOT && state_o != MPSS_BOOT
		|-> state_o == MPSS_FUSE_LOAD || (state_o == MPSS_ACT_RUN && run == BOOT_CYC))
		else $error("boot length");
	min_power_a: assert property (state_o == MPSS_MIN_ENERGY
		|-> pwr_o.min_energy && !pwr_o.cpu_clk_en) else $error("minimum energy");
	run_clocks_a: assert property (state_o == MPSS_ACT_RUN
		|-> pwr_o.relax_osc_en && pwr_o.cpu_clk_en) else $error("active clocks");
	doze_entry_a: assert property ($rose(state_o == MPSS_DOZE) |-> !$past(busy))
		else $error("doze while busy");
	doze_keep_a: assert property (state_o == MPSS_DOZE
		|-> pwr_o.lf_osc_en && pwr_o.retain && !pwr_o.cpu_clk_en) else $error("doze power");
	lf_tick_a: assert property (lf_tick_o |=> lf_time_o == $past(lf_time_o) + 32'h00000001)
		else $error("tick did not count");
	// Main paths
	cover property (state_o == MPSS_FLASH_EMU);
	cover property (state_o == MPSS_MIN_ENERGY);
	cover property (state_o == MPSS_DOZE ##1 state_o == MPSS_ACT_RUN);
endmodule // mpss_asserts

bind mpss_sequencer mpss_asserts #(.FUSE_CYC(FUSE_CYC), .BOOT_CYC(BOOT_CYC)) mpss_asserts_inst (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .act_i(act_i), .pwr_o(pwr_o),
	.state_o(state_o), .lf_time_o(lf_time_o), .lf_tick_o(lf_tick_o));

// File: test/mpss_companion.sv
// Companion processor model driving the reset and programming pins
`timescale 1ns/1ns
module mpss_companion (
	// Clock and requests
	input wire logic clk_i,
	input wire logic hold_i,
	input wire logic prog_i,
	// Pins into the sequencer
	output logic rst_low_o,
	output logic fpe_low_o
);
	// Programming enable goes low only together with reset
	always_ff @(posedge clk_i) begin
		rst_low_o <= !hold_i;
		fpe_low_o <= !(hold_i && prog_i);
	end
endmodule // mpss_companion

// File: test/tb_top.sv
// Self-checking bench for the power-state sequencer
`timescale 1ns/1ns
module tb_top import mpss_pkg::*; ;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic hold = 1'b0;
	logic prog = 1'b0;
	logic strobe_low = 1'b1;
	logic uart_rx = 1'b1;
	logic [15:0] fuse_dir = 16'hA5C3;
	mpss_activity_t act = 5'h10;
	logic rst_low, fpe_low, lf_tick;
	mpss_power_t pwr;
	mpss_state_t state;
	logic [15:0] io_dir;
	logic [31:0] lf_time;
	int fail_count = 0;
	int compares = 0;
	always #5 clk_i = ~clk_i;
	mpss_companion mpss_companion_inst (.clk_i(clk_i), .hold_i(hold), .prog_i(prog),
		.rst_low_o(rst_low), .fpe_low_o(fpe_low));
	// Short counts keep the run brief
	mpss_sequencer #(.FUSE_CYC(4), .BOOT_CYC(4)) mpss_sequencer_inst (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .ext_reset_low_i(rst_low), .flash_program_enable_low_i(fpe_low),
		.time_strobe_low_i(strobe_low), .uart_rx_i(uart_rx), .fuse_dir_i(fuse_dir), .act_i(act),
		.pwr_o(pwr), .io_dir_o(io_dir), .state_o(state), .lf_time_o(lf_time), .lf_tick_o(lf_tick));
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Bounded wait for a state, judged once the edge has settled
	task automatic await(mpss_state_t s, int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			#1;
			if (state === s) break;
		end
		check("state", state, s);
	endtask
	task automatic t_boot();
		await(MPSS_ACT_RUN, 40);
		check("io dir", io_dir, 16'hA5C3);
		check("run clocks", {pwr.relax_osc_en, pwr.cpu_clk_en}, 2'b11);
		$display("test boot done");
	endtask
	task automatic t_emu();
		@(posedge clk_i);
		hold <= 1'b1;
		prog <= 1'b1;
		await(MPSS_FLASH_EMU, 20);
		check("emu flag", pwr.flash_emu, 1'b1);
		@(posedge clk_i);
		hold <= 1'b0;
		prog <= 1'b0;
		await(MPSS_BOOT, 10);
		await(MPSS_ACT_RUN, 10);
		$display("test emu done");
	endtask
	task automatic t_min();
		@(posedge clk_i);
		hold <= 1'b1;
		fuse_dir <= 16'h3C5A;
		await(MPSS_MIN_ENERGY, 20);
		check("io dir", io_dir, 16'h3C5A);
		check("min power", {pwr.min_energy, pwr.cpu_clk_en, pwr.relax_osc_en}, 3'b100);
		@(posedge clk_i);
		hold <= 1'b0;
		await(MPSS_ACT_RUN, 20);
		$display("test min done");
	endtask
	task automatic t_ops();
		logic [31:0] t;
		@(posedge clk_i);
		act <= 5'h0C;
		await(MPSS_ACT_IDLE, 5);
		check("idle power", {pwr.cpu_clk_en, pwr.periph_en, pwr.relax_osc_en}, 3'b011);
		repeat (5) @(posedge clk_i);
		#1;
		check("no doze", state, MPSS_ACT_IDLE);
		@(posedge clk_i);
		act <= 5'h00;
		await(MPSS_DOZE, 5);
		check("doze power", {pwr.retain, pwr.lf_osc_en, pwr.cpu_clk_en}, 3'b110);
		// Tick pulse is judged after the edge so its own launch is not raced
		for (int i = 0; i < 4000 && lf_tick !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		check("lf tick", lf_tick, 1'b1);
		t = lf_time;
		@(posedge clk_i);
		#1;
		check("lf time", lf_time, t + 32'h00000001);
		check("doze held", state, MPSS_DOZE);
		@(posedge clk_i);
		strobe_low <= 1'b0;
		await(MPSS_ACT_RUN, 10);
		await(MPSS_DOZE, 5);
		@(posedge clk_i);
		act <= 5'h02;
		await(MPSS_ACT_IDLE, 5);
		@(posedge clk_i);
		act <= 5'h10;
		await(MPSS_ACT_RUN, 5);
		// Second doze: a UART edge wakes it, then an io_wake request
		@(posedge clk_i);
		act <= 5'h00;
		await(MPSS_DOZE, 5);
		@(posedge clk_i);
		uart_rx <= 1'b0;
		await(MPSS_ACT_RUN, 10);
		await(MPSS_DOZE, 5);
		@(posedge clk_i);
		act <= 5'h01;
		await(MPSS_ACT_IDLE, 5);
		@(posedge clk_i);
		act <= 5'h00;
		await(MPSS_DOZE, 5);
		@(posedge clk_i);
		act <= 5'h10;
		await(MPSS_ACT_RUN, 5);
		$display("test ops done");
	endtask
	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_boot();
		t_emu();
		t_min();
		t_ops();
		close_out();
	end
	// Watchdog: the tests need well under 6000 cycles
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
endmodule // tb_top
